// file: rtl/adaptive_gate_drive_sequencer.sv
// Turn-on and turn-off phase sequencer for one high-side or low-side PWM half-bridge channel
`timescale 1ns/100ps
`default_nettype none
module adaptive_gate_drive_sequencer
	import gate_seq_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic              pwm_channel_input,
	input  wire logic              pwm_channel_enable,
	input  wire logic [1:0]        adaptive_gate_mode,
	input  wire logic              adaptation_filter_enable,
	input  wire logic              adaptation_step_size,
	input  wire logic              postcharge_disable,
	input  wire logic              low_side_pwm,
	input  wire logic [CODE_W-1:0] precharge_initial_current,
	input  wire logic [CODE_W-1:0] predischarge_initial_current,
	input  wire logic [CODE_W-1:0] charge_current,
	input  wire logic [CODE_W-1:0] discharge_current,
	input  wire logic [CODE_W-1:0] maximum_drive_current,
	input  wire logic [CODE_W-1:0] freewheel_drive_current,
	input  wire logic [1:0]        precharge_duration_field,
	input  wire logic [1:0]        predischarge_duration_field,
	input  wire logic [TIME_W-1:0] freewheel_protection_interval,
	input  wire logic [TIME_W-1:0] active_protection_interval,
	input  wire logic [TIME_W-1:0] overvoltage_filter_time,
	input  wire logic [TIME_W-1:0] turn_on_delay,
	input  wire logic [TIME_W-1:0] turn_off_delay,
	input  wire logic              switch_node_high_threshold,
	input  wire logic              switch_node_low_threshold,
	output logic [CODE_W-1:0]      upper_switch_code,
	output logic                   upper_switch_source,
	output logic                   upper_switch_sink,
	output logic [CODE_W-1:0]      lower_switch_code,
	output logic                   lower_switch_source,
	output logic                   lower_switch_sink,
	output logic [TIME_W-1:0]      measured_turn_on_delay,
	output logic [TIME_W-1:0]      measured_turn_off_delay,
	output logic [CODE_W-1:0]      precharge_current,
	output logic [CODE_W-1:0]      predischarge_current,
	output logic [9:0]             sequence_phase
);

	seq_regs_t         r;
	seq_regs_t         n;
	logic              pwm;
	logic              node_hi;
	logic              node_lo;
	logic              on_event;
	logic              off_event;
	logic              act_done;
	logic              phase_done;
	logic              tick;
	logic              enable_load;
	logic              on_issue;
	logic              off_issue;

	adapt_if pre_link ();
	adapt_if pdis_link ();

	gate_current_adapter u_precharge_adapter (
		.ref_clk (ref_clk),
		.rst     (rst),
		.link    (pre_link)
	);

	gate_current_adapter u_predischarge_adapter (
		.ref_clk (ref_clk),
		.rst     (rst),
		.link    (pdis_link)
	);

	// Only the second stage is read by the logic
	assign pwm = r.sync2[SYNC_PWM];
	assign node_hi = r.sync2[SYNC_HI];
	assign node_lo = r.sync2[SYNC_LO];

	// Thresholds swap roles when the channel drives the lower switch
	assign on_event = low_side_pwm ? ~node_hi : node_lo;
	assign off_event = low_side_pwm ? node_lo : ~node_hi;

	assign act_done = r.act_run && (r.act_cnt == 8'h00);
	assign phase_done = (r.phase_cnt == 8'h00);
	assign tick = (r.tick_cnt >= TICK_LAST);
	assign enable_load = pwm_channel_enable & ~r.en_prev;

	// Verdicts wait until the phase using that current is not running
	assign on_issue = r.on_pend && (r.state != ST_PRECHG);
	assign off_issue = r.off_pend && (r.state != ST_PREDIS);

	assign pre_link.valid = on_issue;
	assign pre_link.too_long = r.on_long;
	assign pre_link.too_short = r.on_short;
	assign pre_link.load = enable_load;
	assign pre_link.step_two = adaptation_step_size;
	assign pre_link.filter_on = adaptation_filter_enable;
	assign pre_link.adapt_on = adaptive_gate_mode[1];
	assign pre_link.init_code = precharge_initial_current;
	assign pre_link.max_code = maximum_drive_current;

	assign pdis_link.valid = off_issue;
	assign pdis_link.too_long = r.off_long;
	assign pdis_link.too_short = r.off_short;
	assign pdis_link.load = enable_load;
	assign pdis_link.step_two = adaptation_step_size;
	assign pdis_link.filter_on = adaptation_filter_enable;
	assign pdis_link.adapt_on = adaptive_gate_mode[1];
	assign pdis_link.init_code = predischarge_initial_current;
	assign pdis_link.max_code = maximum_drive_current;

	always_comb begin
		n = r;
		n.sync1 = {switch_node_low_threshold, switch_node_high_threshold, pwm_channel_input};
		n.sync2 = r.sync1;
		n.en_prev = pwm_channel_enable;
		n.tick_cnt = tick ? 4'h0 : 4'(r.tick_cnt + 4'h1);
		if (on_issue) begin
			n.on_pend = 1'b0;
		end
		if (off_issue) begin
			n.off_pend = 1'b0;
		end
		if (r.phase_cnt != 8'h00) begin
			n.phase_cnt = 8'(r.phase_cnt - 8'h01);
		end

		// Active protection runs beside predischarge and discharge
		if (r.act_run) begin
			if (r.act_cnt == 8'h00) begin
				n.act_run = 1'b0;
			end else begin
				n.act_cnt = 8'(r.act_cnt - 8'h01);
			end
		end

		// One shared delay counter; both measurements never overlap
		if (r.on_meas || r.off_meas) begin
			if (r.meas_cnt != 8'hff) begin
				n.meas_cnt = 8'(r.meas_cnt + 8'h01);
			end
		end
		if (r.on_meas && on_event) begin
			n.on_meas = 1'b0;
			n.ton = r.meas_cnt;
			n.on_pend = 1'b1;
			n.on_long = (r.meas_cnt > turn_on_delay);
			n.on_short = (r.meas_cnt < turn_on_delay);
		end
		if (r.off_meas && off_event) begin
			n.off_meas = 1'b0;
			n.toff = r.meas_cnt;
			n.off_pend = 1'b1;
			n.off_long = (r.meas_cnt > turn_off_delay);
			n.off_short = (r.meas_cnt < turn_off_delay);
		end

		unique case (r.state)
			ST_OFF: begin
				if (pwm && pwm_channel_enable) begin
					n.state = ST_FW_CCP;
					n.phase_cnt = count_load(freewheel_protection_interval);
					n.off_meas = 1'b0;
				end
			end
			ST_FW_CCP: begin
				if (!pwm) begin
					n.state = ST_OFF;
				end else if (phase_done) begin
					n.state = ST_PRECHG;
					n.phase_cnt = count_load(duration_cycles(precharge_duration_field));
					n.on_meas = 1'b1;
					n.meas_cnt = 8'h00;
				end
			end
			ST_PRECHG: begin
				if (phase_done) begin
					n.state = ST_CHG;
				end
			end
			ST_CHG: begin
				if (node_hi) begin
					if (postcharge_disable) begin
						n.state = ST_ON;
					end else begin
						n.state = ST_POSTCHG;
						n.post_code = charge_current;
					end
				end
			end
			ST_POSTCHG: begin
				if (r.post_code >= maximum_drive_current) begin
					n.state = ST_ON;
				end else if (tick) begin
					n.post_code = 5'(r.post_code + 5'h01);
				end
			end
			ST_ON: begin
			end
			ST_SYMM: begin
				if (pwm) begin
					n.state = ST_ON;
				end else if (phase_done) begin
					n.state = ST_PREDIS;
					n.phase_cnt = count_load(duration_cycles(predischarge_duration_field));
					n.act_run = 1'b1;
					n.act_cnt = count_load(active_protection_interval);
					n.off_meas = 1'b1;
					n.meas_cnt = 8'h00;
				end
			end
			ST_PREDIS: begin
				if (act_done) begin
					n.state = ST_LS_FW;
					n.phase_cnt = count_load(overvoltage_filter_time);
				end else if (phase_done) begin
					n.state = ST_DIS;
				end
			end
			ST_DIS: begin
				if (act_done) begin
					n.state = ST_LS_FW;
					n.phase_cnt = count_load(overvoltage_filter_time);
				end
			end
			ST_LS_FW: begin
				if (pwm && pwm_channel_enable) begin
					n.state = ST_FW_CCP;
					n.phase_cnt = count_load(freewheel_protection_interval);
					n.off_meas = 1'b0;
				end else if (phase_done) begin
					n.state = ST_OFF;
				end
			end
			default: begin
				n.state = ST_OFF;
			end
		endcase

		// Falling PWM in precharge, charge, postcharge or on starts symmetrization
		if (!pwm && (r.state inside {ST_PRECHG, ST_CHG, ST_POSTCHG, ST_ON})) begin
			n.state = ST_SYMM;
			n.phase_cnt = count_load(freewheel_protection_interval);
			n.on_meas = 1'b0;
		end
		if (!pwm_channel_enable && !(r.state inside {ST_PREDIS, ST_DIS})) begin
			n.state = ST_OFF;
			n.on_meas = 1'b0;
			n.off_meas = 1'b0;
		end

		// Gate drive follows the state being entered
		n.hs_src = 1'b0;
		n.hs_snk = 1'b1;
		n.hs_code = CURRENT_MIN_CODE;
		n.ls_src = 1'b0;
		n.ls_snk = 1'b1;
		n.ls_code = CURRENT_MIN_CODE;
		unique case (n.state)
			ST_OFF: begin
				n.ls_src = 1'b1;
				n.ls_snk = 1'b0;
			end
			ST_FW_CCP: begin
				n.ls_code = freewheel_drive_current;
			end
			ST_PRECHG: begin
				n.hs_src = 1'b1;
				n.hs_snk = 1'b0;
				n.hs_code = pre_link.code;
			end
			ST_CHG: begin
				n.hs_src = 1'b1;
				n.hs_snk = 1'b0;
				n.hs_code = charge_current;
			end
			ST_POSTCHG: begin
				n.hs_src = 1'b1;
				n.hs_snk = 1'b0;
				n.hs_code = n.post_code;
			end
			ST_ON, ST_SYMM: begin
				n.hs_src = 1'b1;
				n.hs_snk = 1'b0;
				n.hs_code = maximum_drive_current;
			end
			ST_PREDIS: begin
				n.hs_code = pdis_link.code;
			end
			ST_DIS: begin
				n.hs_code = discharge_current;
			end
			ST_LS_FW: begin
				n.hs_code = discharge_current;
				// Freewheel charge only while the node sits below the low threshold
				if (!node_lo) begin
					n.ls_src = 1'b1;
					n.ls_snk = 1'b0;
					n.ls_code = freewheel_drive_current;
				end
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			r <= SEQ_RESET;
		end else begin
			r <= n;
		end
	end

	assign upper_switch_code = r.hs_code;
	assign upper_switch_source = r.hs_src;
	assign upper_switch_sink = r.hs_snk;
	assign lower_switch_code = r.ls_code;
	assign lower_switch_source = r.ls_src;
	assign lower_switch_sink = r.ls_snk;
	assign measured_turn_on_delay = r.ton;
	assign measured_turn_off_delay = r.toff;
	assign precharge_current = pre_link.code;
	assign predischarge_current = pdis_link.code;
	assign sequence_phase = r.state;

endmodule : adaptive_gate_drive_sequencer
`default_nettype wire

// file: rtl/gate_seq_pkg.sv
// Shared constants, state encodings and register layouts of the gate drive sequencer
package gate_seq_pkg;

	localparam int CODE_W = 5;
	localparam int TIME_W = 8;

	localparam logic [CODE_W-1:0] CURRENT_MIN_CODE = 5'h00;

	// Postcharge stepping rate; a tick shorter than the clock becomes one cycle
	localparam int CLK_PERIOD_PS       = 100000;
	localparam int POSTCHARGE_TICK_PS  = 62500;
	localparam int TICK_CYCLES_RAW     = POSTCHARGE_TICK_PS / CLK_PERIOD_PS;
	localparam int TICK_CYCLES         = (TICK_CYCLES_RAW < 1) ? 1 : TICK_CYCLES_RAW;
	localparam logic [3:0] TICK_LAST   = 4'(TICK_CYCLES - 1);

	// Cycles per step of the two-bit precharge and predischarge duration fields
	localparam logic [TIME_W-1:0] PHASE_UNIT_CYCLES = 8'h02;

	// Synchroniser lanes
	localparam int SYNC_PWM = 0;
	localparam int SYNC_HI  = 1;
	localparam int SYNC_LO  = 2;

	typedef enum logic [9:0] {
		ST_OFF     = 10'h001,
		ST_FW_CCP  = 10'h002,
		ST_PRECHG  = 10'h004,
		ST_CHG     = 10'h008,
		ST_POSTCHG = 10'h010,
		ST_ON      = 10'h020,
		ST_SYMM    = 10'h040,
		ST_PREDIS  = 10'h080,
		ST_DIS     = 10'h100,
		ST_LS_FW   = 10'h200
	} seq_state_t;

	typedef struct packed {
		seq_state_t        state;
		logic [2:0]        sync1;
		logic [2:0]        sync2;
		logic              en_prev;
		logic [TIME_W-1:0] phase_cnt;
		logic [TIME_W-1:0] act_cnt;
		logic              act_run;
		logic [TIME_W-1:0] meas_cnt;
		logic              on_meas;
		logic              off_meas;
		logic [TIME_W-1:0] ton;
		logic [TIME_W-1:0] toff;
		logic              on_pend;
		logic              on_long;
		logic              on_short;
		logic              off_pend;
		logic              off_long;
		logic              off_short;
		logic [CODE_W-1:0] post_code;
		logic [3:0]        tick_cnt;
		logic [CODE_W-1:0] hs_code;
		logic              hs_src;
		logic              hs_snk;
		logic [CODE_W-1:0] ls_code;
		logic              ls_src;
		logic              ls_snk;
	} seq_regs_t;

	localparam seq_regs_t SEQ_RESET = '{state: ST_OFF, hs_snk: 1'h1, ls_snk: 1'h1, default: '0};

	typedef struct packed {
		logic [CODE_W-1:0] code;
		logic              prev_long;
		logic              prev_short;
	} adapt_regs_t;

	localparam adapt_regs_t ADAPT_RESET = '{code: CURRENT_MIN_CODE, default: '0};

	function automatic logic [TIME_W-1:0] duration_cycles(input logic [1:0] field);
		return 8'(({6'h00, field} + 8'h01) * PHASE_UNIT_CYCLES);
	endfunction : duration_cycles

	// Down-counter preload so a phase of v cycles lasts v cycles, never less than one
	function automatic logic [TIME_W-1:0] count_load(input logic [TIME_W-1:0] v);
		return (v == 8'h00) ? 8'h00 : 8'(v - 8'h01);
	endfunction : count_load

endpackage : gate_seq_pkg

// file: rtl/adapt_if.sv
// Link between the sequencer and one adaptive current regulator
`timescale 1ns/100ps
`default_nettype none
interface adapt_if;
	import gate_seq_pkg::*;
	logic              valid;
	logic              too_long;
	logic              too_short;
	logic              load;
	logic              step_two;
	logic              filter_on;
	logic              adapt_on;
	logic [CODE_W-1:0] init_code;
	logic [CODE_W-1:0] max_code;
	logic [CODE_W-1:0] code;

	modport sequencer (
		output valid, too_long, too_short, load, step_two, filter_on, adapt_on,
		output init_code, max_code,
		input  code
	);
	modport adapter (
		input  valid, too_long, too_short, load, step_two, filter_on, adapt_on,
		input  init_code, max_code,
		output code
	);
endinterface : adapt_if
`default_nettype wire

// file: rtl/gate_current_adapter.sv
// Adaptive current regulator for one precharge or predischarge current code
`timescale 1ns/100ps
`default_nettype none
module gate_current_adapter
	import gate_seq_pkg::*;
(
	input wire logic   ref_clk,
	input wire logic   rst,
	adapt_if.adapter   link
);

	adapt_regs_t       r;
	adapt_regs_t       n;
	logic [CODE_W:0]   step;
	logic [CODE_W:0]   sum;
	logic [CODE_W-1:0] init_lim;
	logic              up;
	logic              down;

	always_comb begin
		n = r;
		step = link.step_two ? 6'h02 : 6'h01;
		sum = {1'b0, r.code} + step;
		init_lim = (link.init_code < link.max_code) ? link.init_code : link.max_code;
		// Filter demands two agreeing verdicts in a row
		up = link.filter_on ? (link.too_long & r.prev_long) : link.too_long;
		down = link.filter_on ? (link.too_short & r.prev_short) : link.too_short;
		if (link.load) begin
			n.code = init_lim;
			n.prev_long = 1'b0;
			n.prev_short = 1'b0;
		end else if (link.valid) begin
			n.prev_long = link.too_long;
			n.prev_short = link.too_short;
			if (link.adapt_on) begin
				if (up) begin
					n.code = (sum > {1'b0, link.max_code}) ? link.max_code : sum[CODE_W-1:0];
				end else if (down) begin
					n.code = ({1'b0, r.code} < ({1'b0, CURRENT_MIN_CODE} + step)) ?
						CURRENT_MIN_CODE : 5'(r.code - step[CODE_W-1:0]);
				end
			end
		end
		// A lowered maximum takes effect at once
		if (n.code > link.max_code) begin
			n.code = link.max_code;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			r <= ADAPT_RESET;
		end else begin
			r <= n;
		end
	end

	assign link.code = r.code;

endmodule : gate_current_adapter
`default_nettype wire

// file: testbench/gate_seq_asserts.sv
// Port-level property checks of the gate drive sequencer
`timescale 1ns/100ps
`default_nettype none
module gate_seq_asserts
	import gate_seq_pkg::*;
(
	input wire logic              ref_clk,
	input wire logic              rst,
	input wire logic              pwm_channel_input,
	input wire logic              pwm_channel_enable,
	input wire logic [1:0]        adaptive_gate_mode,
	input wire logic              postcharge_disable,
	input wire logic [CODE_W-1:0] precharge_initial_current,
	input wire logic [CODE_W-1:0] maximum_drive_current,
	input wire logic [CODE_W-1:0] charge_current,
	input wire logic [CODE_W-1:0] discharge_current,
	input wire logic [CODE_W-1:0] freewheel_drive_current,
	input wire logic [CODE_W-1:0] upper_switch_code,
	input wire logic              upper_switch_source,
	input wire logic              upper_switch_sink,
	input wire logic [CODE_W-1:0] lower_switch_code,
	input wire logic              lower_switch_source,
	input wire logic              lower_switch_sink,
	input wire logic [CODE_W-1:0] precharge_current,
	input wire logic [CODE_W-1:0] predischarge_current,
	input wire logic [9:0]        sequence_phase
);
	default clocking
		@(posedge ref_clk);
	endclocking
	default disable iff (rst);
	logic [CODE_W-1:0] lim;
	assign lim = (precharge_initial_current < maximum_drive_current) ?
		precharge_initial_current : maximum_drive_current;
	sequence quiet_s;
		!adaptive_gate_mode[1] && pwm_channel_enable && $stable(maximum_drive_current);
	endsequence
	AST_SYNC_START: assert property ($rose(sequence_phase == ST_FW_CCP) |->
		$past(pwm_channel_input, 2) || $past(pwm_channel_input, 3) || $past(pwm_channel_input, 4))
		else $error("turn-on without pwm");
	AST_FW_DRIVE: assert property (sequence_phase == ST_FW_CCP |-> lower_switch_sink &&
		lower_switch_code == freewheel_drive_current && !upper_switch_source)
		else $error("freewheel drive wrong");
	AST_PRECHG_DRIVE: assert property (sequence_phase == ST_PRECHG |->
		upper_switch_source && upper_switch_code == precharge_current)
		else $error("precharge drive wrong");
	AST_CHG_DRIVE: assert property (sequence_phase == ST_CHG |->
		upper_switch_source && upper_switch_code == charge_current)
		else $error("charge drive wrong");
	AST_POST_STEP: assert property ((sequence_phase == ST_POSTCHG)[*2] |->
		upper_switch_code == $past(upper_switch_code) + 5'h01 ||
		upper_switch_code == maximum_drive_current)
		else $error("postcharge step wrong");
	AST_NO_POST: assert property (postcharge_disable |-> sequence_phase != ST_POSTCHG)
		else $error("postcharge not skipped");
	AST_ADAPT_OFF: assert property (quiet_s [*3] |->
		$stable(precharge_current) && $stable(predischarge_current))
		else $error("adaptation while off");
	AST_ENABLE_LOAD: assert property ($rose(pwm_channel_enable) |=>
		precharge_current == $past(lim))
		else $error("enable load wrong");
	AST_CLAMP: assert property ($stable(maximum_drive_current) |->
		precharge_current <= maximum_drive_current && predischarge_current <= maximum_drive_current)
		else $error("code above maximum");
	AST_PREDIS_DRIVE: assert property (sequence_phase == ST_PREDIS |-> upper_switch_sink &&
		!upper_switch_source && upper_switch_code == predischarge_current)
		else $error("predischarge drive wrong");
	AST_DIS_DRIVE: assert property (sequence_phase == ST_DIS |->
		upper_switch_sink && upper_switch_code == discharge_current)
		else $error("discharge drive wrong");
	AST_ACT_HOLD: assert property (sequence_phase == ST_PREDIS ||
		sequence_phase == ST_DIS |-> !lower_switch_source)
		else $error("lower gate not held off");
	AST_STABLE_PRE: assert property ((sequence_phase == ST_PRECHG)[*2] |->
		$stable(precharge_current))
		else $error("precharge code moved in phase");
	cover property (sequence_phase == ST_POSTCHG);
	cover property (sequence_phase == ST_DIS);
	cover property ($changed(predischarge_current));
endmodule : gate_seq_asserts
bind adaptive_gate_drive_sequencer gate_seq_asserts gate_seq_asserts_inst (.ref_clk, .rst,
	.pwm_channel_input, .pwm_channel_enable, .adaptive_gate_mode, .postcharge_disable,
	.precharge_initial_current, .maximum_drive_current, .charge_current, .discharge_current,
	.freewheel_drive_current, .upper_switch_code, .upper_switch_source, .upper_switch_sink,
	.lower_switch_code, .lower_switch_source, .lower_switch_sink, .precharge_current,
	.predischarge_current, .sequence_phase);
`default_nettype wire

// file: testbench/bridge_model.sv
// Half-bridge switch node model answering the upper gate drive
`timescale 1ns/100ps
`default_nettype none
module bridge_model (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       upper_switch_source,
	input  wire logic       upper_switch_sink,
	input  wire logic [7:0] on_lag,
	input  wire logic [7:0] off_lag,
	output logic            switch_node_high_threshold,
	output logic            switch_node_low_threshold
);
	logic [8:0] on_reg;
	logic [8:0] off_reg;
	// Counters saturate so a long idle stretch never wraps back
	always_ff @(posedge ref_clk) begin
		if (rst || upper_switch_sink || !upper_switch_source)
			on_reg <= '0;
		else if (on_reg != 9'h1ff)
			on_reg <= on_reg + 9'h001;
		if (rst)
			off_reg <= 9'h1ff;
		else if (upper_switch_source)
			off_reg <= '0;
		else if (off_reg != 9'h1ff)
			off_reg <= off_reg + 9'h001;
	end
	// Low threshold crossed first going up and last going down
	always_comb begin
		if (upper_switch_source) begin
			switch_node_low_threshold  = on_reg >= {1'b0, on_lag};
			switch_node_high_threshold = on_reg >= {1'b0, on_lag} + 9'h002;
		end else begin
			switch_node_high_threshold = off_reg < {1'b0, off_lag};
			switch_node_low_threshold  = off_reg < {1'b0, off_lag} + 9'h002;
		end
	end
endmodule : bridge_model
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench of the gate drive sequencer with a switch node model
`timescale 1ns/100ps
`default_nettype none
module tb
	import gate_seq_pkg::*;
;
	logic ref_clk, rst, pwm_channel_input, pwm_channel_enable, adaptation_filter_enable, clr;
	logic adaptation_step_size, postcharge_disable, low_side_pwm;
	logic switch_node_high_threshold, switch_node_low_threshold;
	logic upper_switch_source, upper_switch_sink, lower_switch_source, lower_switch_sink;
	logic [1:0] adaptive_gate_mode, precharge_duration_field, predischarge_duration_field;
	logic [CODE_W-1:0] precharge_initial_current, predischarge_initial_current, charge_current;
	logic [CODE_W-1:0] discharge_current, maximum_drive_current, freewheel_drive_current;
	logic [CODE_W-1:0] upper_switch_code, lower_switch_code, precharge_current, predischarge_current;
	logic [TIME_W-1:0] freewheel_protection_interval, active_protection_interval, on_lag, off_lag;
	logic [TIME_W-1:0] overvoltage_filter_time, turn_on_delay, turn_off_delay, seen [10];
	logic [TIME_W-1:0] measured_turn_on_delay, measured_turn_off_delay;
	logic [9:0] sequence_phase;
	int mismatches = 0;
	int checked = 0;
	adaptive_gate_drive_sequencer adaptive_gate_drive_sequencer_inst (.ref_clk, .rst,
		.pwm_channel_input, .pwm_channel_enable, .adaptive_gate_mode, .adaptation_filter_enable,
		.adaptation_step_size, .postcharge_disable, .low_side_pwm, .precharge_initial_current,
		.predischarge_initial_current, .charge_current, .discharge_current,
		.maximum_drive_current, .freewheel_drive_current, .precharge_duration_field,
		.predischarge_duration_field, .freewheel_protection_interval, .active_protection_interval,
		.overvoltage_filter_time, .turn_on_delay, .turn_off_delay, .switch_node_high_threshold,
		.switch_node_low_threshold, .upper_switch_code, .upper_switch_source, .upper_switch_sink,
		.lower_switch_code, .lower_switch_source, .lower_switch_sink, .measured_turn_on_delay,
		.measured_turn_off_delay, .precharge_current, .predischarge_current, .sequence_phase);
	bridge_model bridge_model_inst (.ref_clk, .rst, .upper_switch_source, .upper_switch_sink,
		.on_lag, .off_lag, .switch_node_high_threshold, .switch_node_low_threshold);
	always @(posedge ref_clk) begin
		for (int i = 0; i < 10; i++) begin
			if (clr)
				seen[i] <= '0;
			else if (sequence_phase[i] === 1'b1)
				seen[i] <= seen[i] + 8'h01;
		end
	end
	task automatic report_and_stop();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string what, input logic [9:0] exp, got);
		checked++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %0h seen %0h", what, exp, got);
			mismatches++;
		end
	endtask : chk
	task automatic wait_phase(input logic [9:0] p);
		int n = 0;
		#1;
		while (sequence_phase !== p && n < 400) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		if (sequence_phase !== p) begin
			$display("[FAIL] phase wait expected %0h seen %0h", p, sequence_phase);
			mismatches++;
			report_and_stop();
		end
	endtask : wait_phase
	// Ends just after an edge
	task automatic pulse();
		@(posedge ref_clk);
		clr <= 1'b1;
		@(posedge ref_clk);
		clr <= 1'b0;
		pwm_channel_input <= 1'b1;
		wait_phase(10'h020);
		repeat (5) @(posedge ref_clk);
		pwm_channel_input <= 1'b0;
		@(posedge ref_clk);
		wait_phase(10'h001);
		repeat (30) @(posedge ref_clk);
		#1;
	endtask : pulse
	task automatic pulse_expect(input logic [9:0] pre, pdis);
		pulse();
		chk("precharge code", pre, 10'(precharge_current));
		chk("predischarge code", pdis, 10'(predischarge_current));
	endtask : pulse_expect
	task automatic reload(input logic [4:0] ip, id, mx);
		@(posedge ref_clk);
		pwm_channel_enable <= 1'b0;
		precharge_initial_current <= ip;
		predischarge_initial_current <= id;
		maximum_drive_current <= mx;
		repeat (2) @(posedge ref_clk);
		pwm_channel_enable <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask : reload
	task automatic test_sequence();
		@(posedge ref_clk);
		freewheel_protection_interval <= 8'h04;
		precharge_duration_field <= 2'b01;
		predischarge_duration_field <= 2'b10;
		pulse();
		chk("fw interval", 10'h004, 10'(seen[1]));
		chk("precharge len", 10'h004, 10'(seen[2]));
		chk("charge seen", 10'h001, 10'(seen[3] != 8'h00));
		chk("postcharge seen", 10'h001, 10'(seen[4] != 8'h00));
		chk("symm len", 10'h004, 10'(seen[6]));
		chk("predis len", 10'h006, 10'(seen[7]));
		chk("discharge seen", 10'h001, 10'(seen[8] != 8'h00));
		chk("lower fw len", 10'h003, 10'(seen[9]));
		@(posedge ref_clk);
		freewheel_protection_interval <= 8'h07;
		precharge_duration_field <= 2'b00;
		predischarge_duration_field <= 2'b00;
		{postcharge_disable, low_side_pwm} <= 2'b11;
		pulse();
		chk("low side", 10'h000, 10'(measured_turn_on_delay | measured_turn_off_delay));
		chk("fw interval", 10'h007, 10'(seen[1]));
		chk("precharge len", 10'h002, 10'(seen[2]));
		chk("postcharge len", 10'h000, 10'(seen[4]));
		chk("symm len", 10'h007, 10'(seen[6]));
		chk("predis len", 10'h002, 10'(seen[7]));
		$display("test sequence done");
	endtask : test_sequence
	task automatic test_measure();
		logic [7:0] on1, off1;
		@(posedge ref_clk);
		{postcharge_disable, low_side_pwm} <= 2'b00;
		pulse();
		on1 = measured_turn_on_delay;
		off1 = measured_turn_off_delay;
		@(posedge ref_clk);
		on_lag <= 8'h07;
		off_lag <= 8'h08;
		pulse();
		chk("turn on delta", 10'h004, 10'(8'(measured_turn_on_delay - on1)));
		chk("turn off delta", 10'h005, 10'(8'(measured_turn_off_delay - off1)));
		$display("test measure done");
	endtask : test_measure
	task automatic test_adapt();
		reload(5'h0a, 5'h0a, 5'h1f);
		chk("precharge init", 10'h00a, 10'(precharge_current));
		chk("predischarge init", 10'h00a, 10'(predischarge_current));
		pulse_expect(10'h00b, 10'h00b);
		@(posedge ref_clk);
		adaptation_step_size <= 1'b1;
		pulse_expect(10'h00d, 10'h00d);
		@(posedge ref_clk);
		turn_on_delay <= 8'hff;
		turn_off_delay <= 8'hff;
		pulse_expect(10'h00b, 10'h00b);
		@(posedge ref_clk);
		adaptive_gate_mode <= 2'b01;
		pulse_expect(10'h00b, 10'h00b);
		@(posedge ref_clk);
		adaptive_gate_mode <= 2'b11;
		adaptation_filter_enable <= 1'b1;
		adaptation_step_size <= 1'b0;
		turn_on_delay <= 8'h00;
		turn_off_delay <= 8'h00;
		reload(5'h0a, 5'h0a, 5'h1f);
		pulse_expect(10'h00a, 10'h00a);
		pulse_expect(10'h00b, 10'h00b);
		@(posedge ref_clk);
		turn_on_delay <= 8'hff;
		turn_off_delay <= 8'hff;
		pulse_expect(10'h00b, 10'h00b);
		pulse_expect(10'h00a, 10'h00a);
		@(posedge ref_clk);
		adaptation_filter_enable <= 1'b0;
		adaptation_step_size <= 1'b1;
		turn_on_delay <= 8'h00;
		turn_off_delay <= 8'h00;
		reload(5'h14, 5'h05, 5'h0c);
		chk("precharge init", 10'h00c, 10'(precharge_current));
		chk("predischarge init", 10'h005, 10'(predischarge_current));
		pulse_expect(10'h00c, 10'h007);
		$display("test adapt done");
	endtask : test_adapt
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	initial begin
		rst <= 1'b1;
		{clr, pwm_channel_input, pwm_channel_enable, adaptation_filter_enable} <= 4'h0;
		{adaptation_step_size, postcharge_disable, low_side_pwm} <= 3'h0;
		adaptive_gate_mode <= 2'b10;
		precharge_duration_field <= 2'b01;
		predischarge_duration_field <= 2'b10;
		precharge_initial_current <= 5'h0a;
		predischarge_initial_current <= 5'h0a;
		charge_current <= 5'h06;
		discharge_current <= 5'h08;
		maximum_drive_current <= 5'h1f;
		freewheel_drive_current <= 5'h03;
		freewheel_protection_interval <= 8'h04;
		active_protection_interval <= 8'h0c;
		overvoltage_filter_time <= 8'h03;
		{turn_on_delay, turn_off_delay} <= 16'h0000;
		{on_lag, off_lag} <= 16'h0303;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
		chk("reset phase", 10'h001, sequence_phase);
		reload(5'h0a, 5'h0a, 5'h1f);
		test_sequence();
		test_measure();
		test_adapt();
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
